// [rtl/bus_cmd_controller.sv]
// How it works
// R1 - status code selects one command set
// R2 - io strap: io commands ignore bus grant
// R3 - io strap: io commands at once, peripheral transceiver
// R4 - memory commands always wait for bus grant
// R5 - system mode: all commands wait grant delay
// R6 - arbiter grants only when bus is free
// R7 - early writes timed like read commands
// R8 - interrupt acknowledge timed like io read
// R9 - data enable and direction steer transceiver
// R10 - io strap: dual pin is peripheral enable
// R11 - system mode: cascade enable on acknowledge
// R12 - two acknowledge cycles, first moves no data
// R13 - outside logic masks cascade in first cycle
// R14 - cascade enable just before second acknowledge
// R15 - address strobe pulses every machine cycle
// R16 - address strobe also captures status code
// R17 - qualify low holds commands driven inactive
// R18 - direction high transmit, low receive
// R19 - grant released three-states commands at once
// R20 - qualify low forces data enables inactive
// R21 - commands active low, enables per polarity
// R22 - register status, end on passive code
//
// The placing of the registers and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/10ps
module bus_cmd_controller (
  input wire logic clk, // system clock, 50 MHz
  input wire logic resetn, // asynchronous reset, active low
  input wire logic status_code_bit0, // processor status bit 0
  input wire logic status_code_bit1, // processor status bit 1
  input wire logic status_code_bit2, // processor status bit 2
  input wire logic io_bus_strap, // high selects io bus mode
  input wire logic bus_grant_n, // bus grant from arbiter, active low
  input wire logic command_qualify, // high lets commands out
  output logic irq_ack_cmd_n, // interrupt acknowledge command
  output logic io_read_cmd_n, // io read command
  output logic io_write_cmd_n, // io write command
  output logic early_io_write_cmd_n, // early io write command
  output logic mem_read_cmd_n, // memory read command
  output logic mem_write_cmd_n, // memory write command
  output logic early_mem_write_cmd_n, // early memory write command
  output logic io_cmd_oe_n, // io command drivers on, active low
  output logic mem_cmd_oe_n, // memory command drivers on, active low
  output logic addr_latch_strobe, // address latch strobe, active high
  output logic [2:0] status_latched, // status captured by the strobe
  output logic data_xcvr_enable, // data transceiver enable, active high
  output logic xfer_direction, // high transmit, low receive
  output logic cascade_periph_pin, // cascade enable or peripheral enable
  input bus_cmd_pkg::axil_req_t axil_req, // axi4-lite requests
  output bus_cmd_pkg::axil_rsp_t axil_rsp // axi4-lite answers
);

  bus_cmd_pkg::ctl_state_t s_q; // registered state
  bus_cmd_pkg::ctl_state_t s_d; // next state

  logic [2:0] code_in; // status code as sampled this cycle
  bus_cmd_pkg::cmd_set_t dec_cmd; // commands of the latched code
  logic dec_write; // latched cycle is a write
  logic dec_io; // latched cycle uses the io group
  logic dec_ack; // latched cycle is an acknowledge
  logic dec_halt; // latched cycle is a halt
  logic grant_ok; // grant held low for the full delay
  logic qualify; // pin and software qualifier together
  logic io_ok; // io group may be driven active
  logic mem_ok; // memory group may be driven active
  logic aw_take; // write address taken this cycle
  logic w_take; // write data taken this cycle
  logic ar_take; // read address taken this cycle
  bus_cmd_pkg::reg_sel_t wsel; // register hit by the write
  bus_cmd_pkg::reg_sel_t rsel; // register hit by the read
  logic [31:0] status_word; // live status register value

  // map a byte address onto a register
  function automatic bus_cmd_pkg::reg_sel_t reg_select(input logic [7:0] addr);
    if (addr == bus_cmd_pkg::REG_CTRL_OFS)
    begin
      reg_select = bus_cmd_pkg::sel_ctrl;
    end
    else if (addr == bus_cmd_pkg::REG_STATUS_OFS)
    begin
      reg_select = bus_cmd_pkg::sel_status;
    end
    else if (addr == bus_cmd_pkg::REG_CYCLES_OFS)
    begin
      reg_select = bus_cmd_pkg::sel_cycles;
    end
    else
    begin
      reg_select = bus_cmd_pkg::sel_none;
    end
  endfunction

  assign code_in = {status_code_bit2, status_code_bit1, status_code_bit0};

  // decode of the code latched at cycle start
  status_decoder u_decoder (
    .code(s_q.code),
    .cmd(dec_cmd),
    .is_write(dec_write),
    .is_io(dec_io),
    .is_ack(dec_ack),
    .is_halt(dec_halt)
  );

  // bus grant delay
  grant_qualifier u_grant (
    .clk(clk),
    .resetn(resetn),
    .bus_grant_n(bus_grant_n),
    .grant_ok(grant_ok)
  );

  // both qualifiers must be high to let commands out
  assign qualify = command_qualify && s_q.ctrl[bus_cmd_pkg::CTRL_QUAL_BIT]; // R17
  // io group skips arbitration in io bus mode
  assign io_ok = io_bus_strap || grant_ok; // R2 R3
  // memory group always waits for the grant
  assign mem_ok = grant_ok; // R4 R5

  // bus handshakes
  assign aw_take = axil_req.awvalid && !s_q.aw_seen && !s_q.bvalid;
  assign w_take = axil_req.wvalid && !s_q.w_seen && !s_q.bvalid;
  assign ar_take = axil_req.arvalid && !s_q.rvalid;
  assign wsel = reg_select(s_q.aw_addr);
  assign rsel = reg_select(axil_req.araddr);

  // live status for software
  always_comb
  begin
    status_word = '0;
    status_word[bus_cmd_pkg::STAT_CODE_LSB +: 3] = s_q.code;
    status_word[bus_cmd_pkg::STAT_PHASE_LSB +: 2] = s_q.phase;
    status_word[bus_cmd_pkg::STAT_STRAP_BIT] = io_bus_strap;
    status_word[bus_cmd_pkg::STAT_GRANT_BIT] = grant_ok;
    status_word[bus_cmd_pkg::STAT_ACK2_BIT] = s_q.ack_second;
    status_word[bus_cmd_pkg::STAT_HALT_BIT] = dec_halt && (s_q.phase != bus_cmd_pkg::ph_idle);
  end

  // next state of the cycle sequencer, outputs and register slave
  always_comb
  begin
    s_d = s_q;
    s_d.ale = 1'b0;
    // cycle sequencer
    case (s_q.phase)
      bus_cmd_pkg::ph_idle:
      begin
        if (code_in != bus_cmd_pkg::CODE_PASSIVE)
        begin
          s_d.phase = bus_cmd_pkg::ph_addr; // R22
          s_d.code = code_in; // R16 R22
          s_d.ale = 1'b1; // R15
          s_d.cycles = s_q.cycles + 32'h00000001;
          // second of two back-to-back acknowledges
          s_d.ack_second = s_q.prev_ack && (code_in == bus_cmd_pkg::CODE_IRQ_ACK); // R12
          s_d.prev_ack = (code_in == bus_cmd_pkg::CODE_IRQ_ACK) && !s_q.prev_ack;
        end
      end
      bus_cmd_pkg::ph_addr:
      begin
        s_d.phase = bus_cmd_pkg::ph_early;
      end
      bus_cmd_pkg::ph_early:
      begin
        s_d.phase = bus_cmd_pkg::ph_full;
      end
      default:
      begin
        s_d.phase = bus_cmd_pkg::ph_full;
      end
    endcase
    // passive code ends any cycle under way
    if ((s_q.phase != bus_cmd_pkg::ph_idle) && (code_in == bus_cmd_pkg::CODE_PASSIVE))
    begin
      s_d.phase = bus_cmd_pkg::ph_idle; // R22
    end

    // commands: early set from the early phase, normal writes one cycle later
    s_d.cmd = bus_cmd_pkg::CMD_NONE;
    if (s_d.phase == bus_cmd_pkg::ph_early || s_d.phase == bus_cmd_pkg::ph_full)
    begin
      s_d.cmd = dec_cmd;
      if (s_d.phase == bus_cmd_pkg::ph_early)
      begin
        s_d.cmd.io_write = 1'b0; // R7
        s_d.cmd.mem_write = 1'b0; // R7
      end
      if (!io_ok)
      begin
        s_d.cmd.irq_ack = 1'b0; // R5 R8
        s_d.cmd.io_read = 1'b0; // R5
        s_d.cmd.io_write = 1'b0; // R5
        s_d.cmd.early_io_write = 1'b0; // R5
      end
      if (!mem_ok)
      begin
        s_d.cmd.mem_read = 1'b0; // R4
        s_d.cmd.mem_write = 1'b0; // R4
        s_d.cmd.early_mem_write = 1'b0; // R4
      end
      if (!qualify)
      begin
        s_d.cmd = bus_cmd_pkg::CMD_NONE; // R17
      end
    end

    // transceiver enables during the data part of a real transfer
    s_d.xcvr_en = 1'b0;
    s_d.periph_en = 1'b0;
    if ((s_d.phase == bus_cmd_pkg::ph_early || s_d.phase == bus_cmd_pkg::ph_full)
      && !dec_halt && !(dec_ack && !s_q.ack_second) && qualify) // R12 R20
    begin
      if (io_bus_strap && dec_io)
      begin
        s_d.periph_en = 1'b1; // R3 R10
      end
      else if ((dec_io && io_ok) || (!dec_io && mem_ok))
      begin
        s_d.xcvr_en = 1'b1; // R9
      end
    end

    // direction set from the address phase on
    s_d.dir = 1'b0;
    if (s_d.phase != bus_cmd_pkg::ph_idle)
    begin
      s_d.dir = (s_d.phase == bus_cmd_pkg::ph_addr) ?
        ((code_in == bus_cmd_pkg::CODE_IO_WRITE) || (code_in == bus_cmd_pkg::CODE_MEM_WRITE)) :
        dec_write; // R9 R18
    end

    // cascade enable just ahead of each acknowledge command, system mode only
    s_d.cascade = !io_bus_strap && (s_d.phase == bus_cmd_pkg::ph_addr)
      && (s_d.code == bus_cmd_pkg::CODE_IRQ_ACK); // R11 R14

    // write channel: address and data in either order
    if (aw_take)
    begin
      s_d.aw_seen = 1'b1;
      s_d.aw_addr = axil_req.awaddr;
    end
    if (w_take)
    begin
      s_d.w_seen = 1'b1;
      s_d.wdata = axil_req.wdata;
      s_d.wstrb = axil_req.wstrb;
    end
    if (s_q.aw_seen && s_q.w_seen && !s_q.bvalid)
    begin
      s_d.aw_seen = 1'b0;
      s_d.w_seen = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp = bus_cmd_pkg::RESP_OKAY;
      if (wsel == bus_cmd_pkg::sel_ctrl)
      begin
        if (s_q.wstrb[0])
        begin
          s_d.ctrl[7:0] = s_q.wdata[7:0];
        end
      end
      else if (wsel == bus_cmd_pkg::sel_none)
      begin
        s_d.bresp = bus_cmd_pkg::RESP_SLVERR;
      end
    end
    else if (s_q.bvalid && axil_req.bready)
    begin
      s_d.bvalid = 1'b0;
    end

    // read channel: answer the cycle after the address
    if (ar_take)
    begin
      s_d.rvalid = 1'b1;
      s_d.rresp = bus_cmd_pkg::RESP_OKAY;
      if (rsel == bus_cmd_pkg::sel_ctrl)
      begin
        s_d.rdata = {24'h000000, s_q.ctrl[7:0]};
      end
      else if (rsel == bus_cmd_pkg::sel_status)
      begin
        s_d.rdata = status_word;
      end
      else if (rsel == bus_cmd_pkg::sel_cycles)
      begin
        s_d.rdata = s_q.cycles;
      end
      else
      begin
        s_d.rdata = 32'h00000000;
        s_d.rresp = bus_cmd_pkg::RESP_SLVERR;
      end
    end
    else if (s_q.rvalid && axil_req.rready)
    begin
      s_d.rvalid = 1'b0;
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
      s_q.phase <= bus_cmd_pkg::ph_idle;
      s_q.code <= bus_cmd_pkg::CODE_PASSIVE;
      s_q.ctrl <= bus_cmd_pkg::CTRL_RESET;
      s_q.cycles <= bus_cmd_pkg::CYCLES_RESET;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // commands leave the block active low
  assign irq_ack_cmd_n = !s_q.cmd.irq_ack; // R21
  assign io_read_cmd_n = !s_q.cmd.io_read; // R21
  assign io_write_cmd_n = !s_q.cmd.io_write; // R21
  assign early_io_write_cmd_n = !s_q.cmd.early_io_write; // R21
  assign mem_read_cmd_n = !s_q.cmd.mem_read; // R21
  assign mem_write_cmd_n = !s_q.cmd.mem_write; // R21
  assign early_mem_write_cmd_n = !s_q.cmd.early_mem_write; // R21

  // memory drivers float the moment the grant is released, io drivers too outside io bus mode; qualify never floats them
  assign mem_cmd_oe_n = !grant_ok; // R19 R6
  assign io_cmd_oe_n = io_bus_strap ? 1'b0 : !grant_ok; // R2 R19

  // strobe and captured status
  assign addr_latch_strobe = s_q.ale; // R15
  assign status_latched = s_q.code; // R16

  // transceiver control
  assign data_xcvr_enable = s_q.xcvr_en; // R9 R21
  assign xfer_direction = s_q.dir; // R18
  // dual pin: peripheral enable (low active) or cascade enable (high active)
  assign cascade_periph_pin = io_bus_strap ? !s_q.periph_en : s_q.cascade; // R10 R11 R21

  // bus answers
  assign axil_rsp.awready = !s_q.aw_seen && !s_q.bvalid;
  assign axil_rsp.wready = !s_q.w_seen && !s_q.bvalid;
  assign axil_rsp.bvalid = s_q.bvalid;
  assign axil_rsp.bresp = s_q.bresp;
  assign axil_rsp.arready = !s_q.rvalid;
  assign axil_rsp.rvalid = s_q.rvalid;
  assign axil_rsp.rdata = s_q.rdata;
  assign axil_rsp.rresp = s_q.rresp;

endmodule

// [rtl/bus_cmd_pkg.sv]
package bus_cmd_pkg;

  // clock rate of the controller
  localparam int CLK_PERIOD_NS = 20;
  // least time from bus grant going low to the first command
  localparam int GRANT_DELAY_NS = 110;
  // least time rounds up to whole cycles
  localparam int GRANT_DELAY_CYC = (GRANT_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // grant counter width and terminal count
  localparam int GRANT_CNT_W = 3;
  localparam logic [GRANT_CNT_W-1:0] GRANT_DELAY_CNT = GRANT_CNT_W'(GRANT_DELAY_CYC);

  // processor status codes, bit 2 down to bit 0
  localparam logic [2:0] CODE_IRQ_ACK = 3'h0;
  localparam logic [2:0] CODE_IO_READ = 3'h1;
  localparam logic [2:0] CODE_IO_WRITE = 3'h2;
  localparam logic [2:0] CODE_HALT = 3'h3;
  localparam logic [2:0] CODE_FETCH = 3'h4;
  localparam logic [2:0] CODE_MEM_READ = 3'h5;
  localparam logic [2:0] CODE_MEM_WRITE = 3'h6;
  localparam logic [2:0] CODE_PASSIVE = 3'h7;

  // register byte offsets
  localparam logic [7:0] REG_CTRL_OFS = 8'h00;
  localparam logic [7:0] REG_STATUS_OFS = 8'h04;
  localparam logic [7:0] REG_CYCLES_OFS = 8'h08;
  // control register: bit 0 is the software command qualifier
  localparam int CTRL_QUAL_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h00000001;
  localparam logic [31:0] CYCLES_RESET = 32'h00000000;
  // status register field positions
  localparam int STAT_CODE_LSB = 0;
  localparam int STAT_PHASE_LSB = 4;
  localparam int STAT_STRAP_BIT = 8;
  localparam int STAT_GRANT_BIT = 9;
  localparam int STAT_ACK2_BIT = 10;
  localparam int STAT_HALT_BIT = 11;
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // one bit per command, active high inside the block
  typedef struct packed {
    logic irq_ack;
    logic io_read;
    logic io_write;
    logic early_io_write;
    logic mem_read;
    logic mem_write;
    logic early_mem_write;
  } cmd_set_t;
  localparam cmd_set_t CMD_NONE = '0;

  // machine cycle phase
  typedef enum logic [1:0] {ph_idle, ph_addr, ph_early, ph_full} phase_t;

  // register selected by an address
  typedef enum logic [1:0] {sel_ctrl, sel_status, sel_cycles, sel_none} reg_sel_t;

  // axi4-lite master to slave
  typedef struct packed {
    logic awvalid;
    logic [7:0] awaddr;
    logic wvalid;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bready;
    logic arvalid;
    logic [7:0] araddr;
    logic rready;
  } axil_req_t;

  // axi4-lite slave to master
  typedef struct packed {
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } axil_rsp_t;

  // grant qualifier state
  typedef struct packed {
    logic [GRANT_CNT_W-1:0] count;
  } grant_state_t;

  // whole state of the controller
  typedef struct packed {
    phase_t phase;
    logic [2:0] code;
    cmd_set_t cmd;
    logic ale;
    logic xcvr_en;
    logic periph_en;
    logic dir;
    logic cascade;
    logic prev_ack;
    logic ack_second;
    logic [31:0] ctrl;
    logic [31:0] cycles;
    logic aw_seen;
    logic [7:0] aw_addr;
    logic w_seen;
    logic [31:0] wdata;
    logic [3:0] wstrb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } ctl_state_t;

endpackage

// [rtl/grant_qualifier.sv]
`timescale 1ns/10ps
module grant_qualifier (
  input wire logic clk, // system clock
  input wire logic resetn, // asynchronous reset, active low
  input wire logic bus_grant_n, // bus grant from arbiter, active low
  output logic grant_ok // grant has been low for the full delay
);

  bus_cmd_pkg::grant_state_t s_q; // registered state
  bus_cmd_pkg::grant_state_t s_d; // next state

  // count cycles of continuous grant, restart at once when released
  always_comb
  begin
    s_d = s_q;
    if (bus_grant_n)
    begin
      s_d.count = '0; // R19
    end
    else if (s_q.count != bus_cmd_pkg::GRANT_DELAY_CNT)
    begin
      s_d.count = s_q.count + 1'b1; // R5
    end
  end

  // state register
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      s_q <= '0;
    end
    else
    begin
      s_q <= s_d;
    end
  end

  // qualified only while the grant is still held low
  assign grant_ok = !bus_grant_n && (s_q.count == bus_cmd_pkg::GRANT_DELAY_CNT); // R5

endmodule

// [rtl/status_decoder.sv]
`timescale 1ns/10ps
module status_decoder (
  input wire logic [2:0] code, // status code, bit 2 down to bit 0
  output bus_cmd_pkg::cmd_set_t cmd, // commands the code selects
  output logic is_write, // cycle writes memory or io
  output logic is_io, // cycle belongs to the io group
  output logic is_ack, // interrupt acknowledge cycle
  output logic is_halt // halt cycle
);

  // code to command table
  always_comb
  begin
    cmd = bus_cmd_pkg::CMD_NONE;
    case (code)
      bus_cmd_pkg::CODE_IRQ_ACK: cmd.irq_ack = 1'b1; // R1
      bus_cmd_pkg::CODE_IO_READ: cmd.io_read = 1'b1; // R1
      bus_cmd_pkg::CODE_IO_WRITE:
      begin
        cmd.io_write = 1'b1; // R1
        cmd.early_io_write = 1'b1; // R1
      end
      bus_cmd_pkg::CODE_FETCH: cmd.mem_read = 1'b1; // R1
      bus_cmd_pkg::CODE_MEM_READ: cmd.mem_read = 1'b1; // R1
      bus_cmd_pkg::CODE_MEM_WRITE:
      begin
        cmd.mem_write = 1'b1; // R1
        cmd.early_mem_write = 1'b1; // R1
      end
      default: cmd = bus_cmd_pkg::CMD_NONE; // halt and passive select nothing
    endcase
  end

  // cycle classes for direction and enables
  assign is_write = (code == bus_cmd_pkg::CODE_IO_WRITE) || (code == bus_cmd_pkg::CODE_MEM_WRITE);
  assign is_io = (code == bus_cmd_pkg::CODE_IO_READ) || (code == bus_cmd_pkg::CODE_IO_WRITE)
    || (code == bus_cmd_pkg::CODE_IRQ_ACK);
  assign is_ack = (code == bus_cmd_pkg::CODE_IRQ_ACK);
  assign is_halt = (code == bus_cmd_pkg::CODE_HALT);

endmodule

// [tb/bus_cmd_monitor.sv]
`timescale 1ns/10ps
// pin checks
module bus_cmd_monitor (
  input wire logic clk, // system clock
  input wire logic resetn, // reset, active low
  input wire logic status_code_bit0, // status bit 0
  input wire logic status_code_bit1, // status bit 1
  input wire logic status_code_bit2, // status bit 2
  input wire logic io_bus_strap, // io bus mode strap
  input wire logic bus_grant_n, // grant, active low
  input wire logic command_qualify, // command qualifier
  input wire logic irq_ack_cmd_n, // ack command
  input wire logic io_read_cmd_n, // io read
  input wire logic io_write_cmd_n, // io write
  input wire logic early_io_write_cmd_n, // early io write
  input wire logic mem_read_cmd_n, // memory read
  input wire logic mem_write_cmd_n, // memory write
  input wire logic early_mem_write_cmd_n, // early memory write
  input wire logic io_cmd_oe_n, // io drivers on
  input wire logic mem_cmd_oe_n, // memory drivers on
  input wire logic addr_latch_strobe, // address strobe
  input wire logic [2:0] status_latched, // latched status
  input wire logic data_xcvr_enable, // data enable
  input wire logic xfer_direction, // direction
  input wire logic cascade_periph_pin // dual pin
);
  logic [2:0] code; // live status code
  logic [6:0] cmds_n; // all command lines
  assign code = {status_code_bit2, status_code_bit1, status_code_bit0};
  assign cmds_n = {irq_ack_cmd_n, io_read_cmd_n, io_write_cmd_n, early_io_write_cmd_n,
    mem_read_cmd_n, mem_write_cmd_n, early_mem_write_cmd_n};
  default clocking @(posedge clk); endclocking
  default disable iff (!resetn);
  chk_strobe_pulse: assert property (addr_latch_strobe |=> !addr_latch_strobe)
    else $error("long strobe");
  chk_strobe_status: assert property (addr_latch_strobe |-> status_latched == $past(code))
    else $error("bad latched status");
  chk_grant_off: assert property (bus_grant_n |-> mem_cmd_oe_n)
    else $error("mem drivers on");
  chk_strap_io: assert property (io_bus_strap |-> !io_cmd_oe_n)
    else $error("io drivers off");
  chk_qualify_off: assert property (!$past(command_qualify) |-> &cmds_n && !data_xcvr_enable)
    else $error("active while unqualified");
  chk_mem_granted: assert property ((!mem_read_cmd_n || !mem_write_cmd_n) |-> !$past(mem_cmd_oe_n))
    else $error("mem command ungranted");
  chk_early_first: assert property ($fell(mem_write_cmd_n) |-> $past(!early_mem_write_cmd_n))
    else $error("write before early write");
  chk_passive_end: assert property ((code == 3'h7) [*2] |=> &cmds_n)
    else $error("command after passive");
  chk_dir_write: assert property (addr_latch_strobe |->
    xfer_direction == (status_latched == 3'h2 || status_latched == 3'h6))
    else $error("bad direction");
  chk_cascade_ack: assert property (!io_bus_strap && cascade_periph_pin |->
    addr_latch_strobe && status_latched == 3'h0)
    else $error("stray cascade");
  cover property (!mem_write_cmd_n);
  cover property (!irq_ack_cmd_n && data_xcvr_enable);
  cover property (io_bus_strap && bus_grant_n && !io_read_cmd_n);
endmodule
bind bus_cmd_controller bus_cmd_monitor mon_inst (.*);

// [tb/cpu_status_model.sv]
`timescale 1ns/10ps
// processor status: one cycle per start
module cpu_status_model (
  input wire logic clk, // system clock
  input wire logic resetn, // reset, active low
  input wire logic start, // begin a machine cycle
  input wire logic [2:0] start_code, // code of the cycle
  input wire logic [3:0] hold_len, // cycle length, slow when large
  output logic status_code_bit0, // status bit 0
  output logic status_code_bit1, // status bit 1
  output logic status_code_bit2, // status bit 2
  output logic busy // cycle under way
);
  logic [2:0] code_q; // driven code
  logic [3:0] hold_q; // cycles left
  // code stands, then passive
  always_ff @(posedge clk or negedge resetn)
  begin
    if (!resetn)
    begin
      code_q <= 3'h7;
      hold_q <= 4'h0;
    end
    else if (hold_q != 4'h0)
    begin
      hold_q <= hold_q - 4'h1;
      if (hold_q == 4'h3)
        code_q <= 3'h7;
    end
    else if (start)
    begin
      code_q <= start_code;
      hold_q <= hold_len;
    end
  end
  assign {status_code_bit2, status_code_bit1, status_code_bit0} = code_q;
  assign busy = hold_q != 4'h0;
endmodule

// [tb/tb.sv]
`timescale 1ns/10ps
module tb;
  logic clk = 1'b0, resetn = 1'b0, start = 1'b0, strap = 1'b0, grant_n = 1'b1, qual = 1'b1;
  logic [2:0] start_code = 3'h7, s_code;
  logic [3:0] hold_len = 4'h8;
  logic busy, gnt_tb, ack_prev;
  logic [6:0] cmd_n;
  logic [5:0] en_out;
  logic [31:0] rnd = 32'd40, strobes;
  bus_cmd_pkg::axil_req_t req = '0;
  bus_cmd_pkg::axil_rsp_t rsp;
  logic [9:0] exp_q[$];
  logic [33:0] rd_q[$];
  int miscompares = 0, tests_run = 0;
  always #10 clk = ~clk;
  cpu_status_model cpu_status_model_inst (.clk, .resetn, .start, .start_code, .hold_len,
    .status_code_bit0(s_code[0]), .status_code_bit1(s_code[1]), .status_code_bit2(s_code[2]),
    .busy);
  bus_cmd_controller bus_cmd_controller_inst (.clk, .resetn, .status_code_bit0(s_code[0]),
    .status_code_bit1(s_code[1]), .status_code_bit2(s_code[2]), .io_bus_strap(strap),
    .bus_grant_n(grant_n), .command_qualify(qual), .irq_ack_cmd_n(cmd_n[6]),
    .io_read_cmd_n(cmd_n[5]), .io_write_cmd_n(cmd_n[4]), .early_io_write_cmd_n(cmd_n[3]),
    .mem_read_cmd_n(cmd_n[2]), .mem_write_cmd_n(cmd_n[1]), .early_mem_write_cmd_n(cmd_n[0]),
    .io_cmd_oe_n(en_out[0]), .mem_cmd_oe_n(en_out[1]), .addr_latch_strobe(en_out[2]),
    .status_latched(), .data_xcvr_enable(en_out[3]), .xfer_direction(en_out[4]),
    .cascade_periph_pin(en_out[5]), .axil_req(req), .axil_rsp(rsp));
  // verdict
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic check(input string nm, input logic [33:0] e, input logic [33:0] g);
    tests_run++;
    if (g !== e)
    begin
      miscompares++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask
  // bound ran out
  task automatic timed_out(input int n);
    if (n > 60)
    begin
      check("wait bound", 34'h0, 34'h1);
      test_done();
    end
  endtask
  // expected pins of a cycle
  function automatic logic [9:0] expect_out(input logic [2:0] c, input logic ack2);
    logic io, en, first;
    logic [6:0] act;
    io = c <= 3'h2;
    first = c == 3'h0 && !ack2;
    en = qual && (io ? (strap || gnt_tb) : (c >= 3'h4 && c <= 3'h6 && gnt_tb));
    act = {c == 3'h0, c == 3'h1, c == 3'h2, c == 3'h2, c == 3'h4 || c == 3'h5, c == 3'h6,
      c == 3'h6};
    return {~(act & {7{en}}), en && !(strap && io) && !first,
      strap ? !(en && io && !first) : 1'b0, c == 3'h2 || c == 3'h6};
  endfunction
  // one machine cycle
  task automatic run_cycle(input logic [2:0] c, input logic [3:0] len);
    int n;
    exp_q.push_back(expect_out(c, ack_prev && c == 3'h0));
    ack_prev = c == 3'h0 && !ack_prev;
    strobes++;
    start <= 1'b1;
    start_code <= c;
    hold_len <= len;
    @(posedge clk);
    start <= 1'b0;
    for (n = 0; n < 2 || busy; n++)
    begin
      @(posedge clk);
      timed_out(n);
    end
  endtask
  task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
    int n;
    req.awvalid <= 1'b1;
    req.awaddr <= a;
    req.wvalid <= 1'b1;
    req.wdata <= d;
    req.wstrb <= 4'hF;
    req.bready <= 1'b1;
    for (n = 0; n >= 0; n++)
    begin
      @(posedge clk);
      timed_out(n);
      if (req.awvalid && rsp.awready)
        req.awvalid <= 1'b0;
      if (req.wvalid && rsp.wready)
        req.wvalid <= 1'b0;
      if (rsp.bvalid === 1'b1)
        break;
    end
    req.bready <= 1'b0;
    check("bresp", {32'h0, bus_cmd_pkg::RESP_OKAY}, {32'h0, rsp.bresp});
  endtask
  task automatic axi_read(input logic [7:0] a, input logic [31:0] d, input logic [1:0] r);
    int n;
    rd_q.push_back({r, d});
    req.arvalid <= 1'b1;
    req.araddr <= a;
    req.rready <= 1'b1;
    for (n = 0; n >= 0; n++)
    begin
      @(posedge clk);
      timed_out(n);
      if (req.arvalid && rsp.arready)
        req.arvalid <= 1'b0;
      if (rsp.rvalid === 1'b1)
        break;
    end
    req.rready <= 1'b0;
  endtask
  // compare two edges after the strobe
  initial forever
  begin
    @(posedge clk);
    if (en_out[2] === 1'b1)
    begin
      repeat (2) @(posedge clk);
      if (exp_q.size() == 0)
        check("unexpected cycle", 34'h0, 34'h1);
      else
        check("pins", {24'h0, exp_q.pop_front()},
          {24'h0, cmd_n, en_out[3], en_out[5], en_out[4]});
    end
  end
  initial forever
  begin
    @(posedge clk);
    if (rsp.rvalid === 1'b1 && req.rready === 1'b1)
      check("rresp/rdata", rd_q.pop_front(), {rsp.rresp, rsp.rdata});
  end
  function automatic logic [31:0] xorshift(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    return x ^ (x << 5);
  endfunction
  task automatic do_reset(input logic s);
    resetn <= 1'b0;
    strap <= s;
    repeat (3) @(posedge clk);
    resetn <= 1'b1;
    ack_prev = 1'b0;
    strobes = 32'h0;
  endtask
  // arbiter grant, settled after 8 edges
  task automatic set_grant(input logic g);
    grant_n <= !g;
    repeat (8) @(posedge clk);
    gnt_tb = g;
  endtask
  initial
  begin
    gnt_tb = 1'b0;
    do_reset(1'b0);
    axi_read(8'h00, bus_cmd_pkg::CTRL_RESET, bus_cmd_pkg::RESP_OKAY);
    axi_read(8'h08, bus_cmd_pkg::CYCLES_RESET, bus_cmd_pkg::RESP_OKAY);
    axi_read(8'h0C, 32'h0, bus_cmd_pkg::RESP_SLVERR);
    set_grant(1'b1);
    qual <= 1'b0;
    axi_write(8'h00, 32'h0);
    run_cycle(3'h5, 4'h8);
    qual <= 1'b1;
    axi_write(8'h00, 32'h1);
    $display("test registers done");
    foreach (start_code[i])
      run_cycle(3'h0, 4'h8);
    for (int c = 1; c < 7; c++)
      run_cycle(3'(c), 4'hC);
    $display("test decode done");
    set_grant(1'b0);
    run_cycle(3'h5, 4'h8);
    run_cycle(3'h2, 4'h8);
    qual <= 1'b0;
    set_grant(1'b1);
    run_cycle(3'h6, 4'h9);
    qual <= 1'b1;
    @(posedge clk);
    $display("test gating done");
    repeat (8)
    begin
      rnd = xorshift(rnd);
      run_cycle(3'(rnd % 7), 4'h8 + 4'(rnd[6:4]));
    end
    axi_read(8'h08, strobes, bus_cmd_pkg::RESP_OKAY);
    $display("test random done");
    gnt_tb = 1'b0;
    grant_n <= 1'b1;
    do_reset(1'b1);
    foreach (cmd_n[i])
      run_cycle(3'(i % 4), 4'h8);
    run_cycle(3'h4, 4'h8);
    set_grant(1'b1);
    run_cycle(3'h6, 4'h8);
    $display("test io bus done");
    test_done();
  end
endmodule
